// ===== include/srs_pkg.sv
// constants, register map and types of the low-power sequencer and reset cause block
package srs_pkg;
  localparam int SRS_AW = 12;
  localparam int SRS_DW = 32;

  // register byte offsets
  localparam logic [11:0] SRS_RSR_OFF = 12'h000;
  localparam logic [11:0] SRS_BFC_OFF = 12'h004;
  localparam logic [11:0] SRS_CFG_OFF = 12'h008;
  localparam logic [11:0] SRS_BSR_OFF = 12'h00c;
  localparam logic [11:0] SRS_MODE_OFF = 12'h010;

  // reset cause status fields
  localparam int SRS_RSR_POR_BIT = 7;
  localparam int SRS_RSR_PIN_BIT = 6;
  localparam int SRS_RSR_WDOG_BIT = 5;
  localparam int SRS_RSR_ILOPC_BIT = 4;
  localparam int SRS_RSR_ILADR_BIT = 3;
  localparam int SRS_RSR_MON_BIT = 2;
  localparam int SRS_RSR_LV_BIT = 1;
  localparam logic [7:0] SRS_RSR_RESET = 8'h80;

  // break flag control, config and break status fields
  localparam int SRS_BFC_CLR_EN_BIT = 7;
  localparam logic [7:0] SRS_BFC_RESET = 8'h00;
  localparam int SRS_CFG_WDOG_DIS_BIT = 0;
  localparam int SRS_CFG_SHORT_REC_BIT = 1;
  localparam int SRS_CFG_OSC_STOP_BIT = 2;
  localparam logic [2:0] SRS_CFG_RESET = 3'h0;
  localparam int SRS_BSR_STOP_WAIT_BIT = 1;

  // stop recovery lengths in pclk cycles
  localparam int SRS_CNT_W = 13;
  localparam logic [12:0] SRS_REC_LONG = 13'h1000;
  localparam logic [12:0] SRS_REC_SHORT = 13'h0020;

  typedef enum logic [1:0] {
    SRS_RUN = 2'b00,
    SRS_WAIT = 2'b01,
    SRS_STOP = 2'b11,
    SRS_RECOV = 2'b10
  } srs_state_t;
endpackage

// ===== core/srs_core.sv
// low-power mode sequencer, reset cause status and break flag protection with apb slave
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module srs_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [srs_pkg::SRS_AW-1:0] paddr,
  input wire logic [srs_pkg::SRS_DW-1:0] pwdata,
  output logic [srs_pkg::SRS_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu side
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic module_irq,
  output logic imask_clear,
  output logic irq_stack_start,
  // break module side
  input wire logic break_active,
  input wire logic break_irq,
  // reset sources, one-cycle pulses; the last two are level qualifiers of the monitor entry flag
  input wire logic pin_reset_event,
  input wire logic watchdog_reset_event,
  input wire logic illegal_opcode_event,
  input wire logic illegal_address_event,
  input wire logic monitor_entry_event,
  input wire logic low_voltage_event,
  input wire logic reset_vector_erased,
  input wire logic irq_at_test_voltage,
  // clock gating and peripheral controls
  output logic cpu_clock_en,
  output logic bus_clock_x2_en,
  output logic bus_clock_x4_en,
  output logic watchdog_enable,
  output logic flag_clear_allowed
);
  import srs_pkg::*;

  srs_state_t state_reg;
  srs_state_t state_next;
  logic [7:0] rsr_reg;
  logic [7:0] rsr_snap_reg;
  logic [7:0] rsr_set;
  logic [7:0] rsr_clr;
  logic [7:0] bfc_reg;
  logic [2:0] cfg_reg;
  logic break_stop_wait_flag;
  logic stack_pend_reg;
  logic [SRS_CNT_W-1:0] rec_cnt_reg;
  logic rec_done_reg;
  logic [SRS_CNT_W-1:0] rec_limit;
  logic [SRS_DW-1:0] rd_next;
  logic prdata_valid;
  logic [SRS_DW-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic hit_rsr;
  logic hit_bfc;
  logic hit_cfg;
  logic hit_bsr;
  logic hit_mode;
  logic wr_acc;
  logic rd_acc;
  logic clear_ok;
  logic any_reset;
  logic wake_irq;
  logic wake_any;
  logic break_flag_clear_enable;
  logic watchdog_disable;
  logic short_stop_recovery;
  logic osc_run_in_stop;
  logic imask_clear_reg;
  logic irq_stack_start_reg;
  logic cpu_clock_en_reg;
  logic x2_en_reg;
  logic x4_en_reg;
  logic watchdog_enable_reg;
  logic flag_clear_allowed_reg;

  assign break_flag_clear_enable = bfc_reg[SRS_BFC_CLR_EN_BIT];
  assign watchdog_disable = cfg_reg[SRS_CFG_WDOG_DIS_BIT];
  assign short_stop_recovery = cfg_reg[SRS_CFG_SHORT_REC_BIT];
  assign osc_run_in_stop = cfg_reg[SRS_CFG_OSC_STOP_BIT];

  // status clears are refused while break is active unless enabled
  assign clear_ok = ~break_active | break_flag_clear_enable;

  // apb phases and address decode
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable & pready_reg;
  assign hit_rsr = (paddr == SRS_RSR_OFF);
  assign hit_bfc = (paddr == SRS_BFC_OFF);
  assign hit_cfg = (paddr == SRS_CFG_OFF);
  assign hit_bsr = (paddr == SRS_BSR_OFF);
  assign hit_mode = (paddr == SRS_MODE_OFF);
  assign mapped = hit_rsr | hit_bfc | hit_cfg | hit_bsr | hit_mode;
  assign wr_acc = access_ph & pwrite & mapped;
  assign rd_acc = access_ph & ~pwrite & mapped;

  // no wait states: ready is raised in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_ph;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= setup_ph & ~mapped;
    end
  end

  always_comb begin
    rd_next = '0;
    if (hit_rsr) begin
      rd_next[7:0] = rsr_reg;
    end else if (hit_bfc) begin
      rd_next[7:0] = bfc_reg;
    end else if (hit_cfg) begin
      rd_next[2:0] = cfg_reg;
    end else if (hit_bsr) begin
      rd_next[SRS_BSR_STOP_WAIT_BIT] = break_stop_wait_flag;
    end else if (hit_mode) begin
      rd_next[1:0] = state_reg;
      rd_next[2] = rec_done_reg;
      rd_next[3] = stack_pend_reg;
    end
  end

  // read data is taken in the setup cycle, so it holds the pre-clear flags
  assign prdata_valid = setup_ph & ~pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (prdata_valid) begin
      prdata_reg <= rd_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr_snap_reg <= 8'h00;
    end else if (prdata_valid && hit_rsr) begin
      rsr_snap_reg <= rsr_reg;
    end
  end

  // reset cause collection
  always_comb begin
    rsr_set = 8'h00;
    rsr_set[SRS_RSR_PIN_BIT] = pin_reset_event;
    rsr_set[SRS_RSR_WDOG_BIT] = watchdog_reset_event;
    rsr_set[SRS_RSR_ILOPC_BIT] = illegal_opcode_event;
    rsr_set[SRS_RSR_ILADR_BIT] = illegal_address_event;
    rsr_set[SRS_RSR_MON_BIT] = monitor_entry_event & reset_vector_erased & ~irq_at_test_voltage;
    rsr_set[SRS_RSR_LV_BIT] = low_voltage_event;
  end

  assign any_reset = |rsr_set;

  // only the bits software actually saw are cleared, at the end of the read
  always_comb begin
    rsr_clr = 8'h00;
    if (rd_acc && hit_rsr && clear_ok) begin
      rsr_clr = rsr_snap_reg;
    end
  end

  // power-on reset is presetn itself: only the power-on flag comes up set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsr_reg <= SRS_RSR_RESET;
    end else begin
      rsr_reg <= (rsr_reg & ~rsr_clr) | rsr_set;
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bfc_reg <= SRS_BFC_RESET;
    end else if (wr_acc && hit_bfc) begin
      bfc_reg <= {pwdata[SRS_BFC_CLR_EN_BIT], 7'h00};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= SRS_CFG_RESET;
    end else if (wr_acc && hit_cfg) begin
      cfg_reg <= pwdata[2:0];
    end
  end

  // break stop/wait flag: write one to clear, protected in break, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_stop_wait_flag <= 1'b0;
    end else if (break_irq && (state_reg == SRS_WAIT || state_reg == SRS_STOP)) begin
      break_stop_wait_flag <= 1'b1;
    end else if (wr_acc && hit_bsr && pwdata[SRS_BSR_STOP_WAIT_BIT] && clear_ok) begin
      // a cleared flag is never restored when break ends
      break_stop_wait_flag <= 1'b0;
    end
  end

  // peripherals gate every clear step with this, so a two-step clear whose
  // first step came before break cannot finish in break while break_flag_clear_enable is clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_clear_allowed_reg <= 1'b1;
    end else begin
      flag_clear_allowed_reg <= clear_ok;
    end
  end

  // mode sequencing
  assign wake_irq = module_irq | break_irq;
  assign wake_any = wake_irq | any_reset;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SRS_RUN: begin
        if (stop_exec) begin
          state_next = SRS_STOP;
        end else if (wait_exec) begin
          state_next = SRS_WAIT;
        end
      end
      SRS_WAIT: begin
        if (wake_any) begin
          state_next = SRS_RUN;
        end
      end
      SRS_STOP: begin
        if (wake_any) begin
          state_next = SRS_RECOV;
        end
      end
      SRS_RECOV: begin
        if (rec_done_reg) begin
          state_next = SRS_RUN;
        end
      end
      default: begin
        state_next = SRS_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SRS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_clear_reg <= 1'b0;
    end else begin
      imask_clear_reg <= (state_reg == SRS_RUN) & (wait_exec | stop_exec);
    end
  end

  // remembers that stop was left by an interrupt or break, not by a reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_pend_reg <= 1'b0;
    end else if (state_reg == SRS_STOP && wake_any) begin
      stack_pend_reg <= wake_irq & ~any_reset;
    end else if (state_reg == SRS_RUN) begin
      stack_pend_reg <= 1'b0;
    end
  end

  // stacking pulse: one cycle after the waking edge in wait, after the
  // full recovery count in stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stack_start_reg <= 1'b0;
    end else if (state_reg == SRS_WAIT) begin
      irq_stack_start_reg <= wake_irq & ~any_reset;
    end else if (state_reg == SRS_RECOV) begin
      irq_stack_start_reg <= rec_done_reg & stack_pend_reg;
    end else begin
      irq_stack_start_reg <= 1'b0;
    end
  end

  // clock gates follow the next state so they change with the mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_en_reg <= 1'b1;
    end else begin
      cpu_clock_en_reg <= (state_next == SRS_RUN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x4_en_reg <= 1'b1;
    end else begin
      x4_en_reg <= (state_next == SRS_RUN) | (state_next == SRS_WAIT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x2_en_reg <= 1'b1;
    end else if (state_next == SRS_STOP || state_next == SRS_RECOV) begin
      x2_en_reg <= osc_run_in_stop;
    end else begin
      x2_en_reg <= 1'b1;
    end
  end

  // watchdog keeps running through wait; it has no clock in stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_enable_reg <= 1'b1;
    end else begin
      watchdog_enable_reg <= ~watchdog_disable & (state_next != SRS_STOP) & (state_next != SRS_RECOV);
    end
  end

  // stop recovery counter on the falling edge; the half-cycle paths from and to the rising
  // edge logic are the timing cost of this choice
  assign rec_limit = short_stop_recovery ? SRS_REC_SHORT : SRS_REC_LONG;

  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt_reg <= '0;
      rec_done_reg <= 1'b0;
    end else if (state_reg != SRS_RECOV) begin
      rec_cnt_reg <= '0;
      rec_done_reg <= 1'b0;
    end else if (!rec_done_reg) begin
      if (rec_cnt_reg == rec_limit - 13'h0001) begin
        rec_done_reg <= 1'b1;
      end else begin
        rec_cnt_reg <= rec_cnt_reg + 13'h0001;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign imask_clear = imask_clear_reg;
  assign irq_stack_start = irq_stack_start_reg;
  assign cpu_clock_en = cpu_clock_en_reg;
  assign bus_clock_x2_en = x2_en_reg;
  assign bus_clock_x4_en = x4_en_reg;
  assign watchdog_enable = watchdog_enable_reg;
  assign flag_clear_allowed = flag_clear_allowed_reg;
endmodule

// ===== verif/srs_core_properties.sv
// port checker for the sequencer and reset cause block
`timescale 1ns/1ps
module srs_core_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // cpu and break side
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic module_irq,
  input wire logic break_irq,
  input wire logic break_active,
  input wire logic imask_clear,
  input wire logic irq_stack_start,
  // clock gating and peripheral controls
  input wire logic cpu_clock_en,
  input wire logic bus_clock_x4_en,
  input wire logic watchdog_enable,
  input wire logic flag_clear_allowed
);
  logic [12:0] rec_cnt_reg;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // counts from a wake request while the bus clocks are off; a reset wake leaves it at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt_reg <= 13'h0000;
    end else if (bus_clock_x4_en) begin
      rec_cnt_reg <= 13'h0000;
    end else if (module_irq || break_irq || rec_cnt_reg != 13'h0000) begin
      rec_cnt_reg <= rec_cnt_reg + 13'h0001;
    end
  end
  ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  imask_clr_a: assert property ((wait_exec || stop_exec) && cpu_clock_en |=> imask_clear)
    else $error("mask not cleared");
  wait_clk_a: assert property (wait_exec && !stop_exec && cpu_clock_en |=> !cpu_clock_en && bus_clock_x4_en)
    else $error("wait clocks wrong");
  stop_clk_a: assert property (stop_exec && cpu_clock_en |=> !cpu_clock_en && !bus_clock_x4_en)
    else $error("stop clocks wrong");
  wait_wake_a: assert property (!cpu_clock_en && bus_clock_x4_en && module_irq |=> cpu_clock_en && irq_stack_start)
    else $error("wait wake missed");
  brk_wake_a: assert property (!cpu_clock_en && bus_clock_x4_en && break_irq |=> cpu_clock_en)
    else $error("break wake missed");
  stack_clk_a: assert property (irq_stack_start |-> cpu_clock_en && bus_clock_x4_en)
    else $error("stacking with clocks off");
  rec_len_a: assert property ($rose(bus_clock_x4_en) && rec_cnt_reg != 13'h0000 |-> rec_cnt_reg >= 13'h0020)
    else $error("recovery too short");
  wdog_wait_a: assert property (wait_exec && !stop_exec && cpu_clock_en && watchdog_enable |=> watchdog_enable)
    else $error("watchdog off in wait");
  brk_open_a: assert property (!break_active |=> flag_clear_allowed)
    else $error("clear blocked out of break");
endmodule
bind srs_core srs_core_properties chk_u (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .wait_exec,
  .stop_exec, .module_irq, .break_irq, .break_active, .imask_clear, .irq_stack_start, .cpu_clock_en,
  .bus_clock_x4_en, .watchdog_enable, .flag_clear_allowed);

// ===== verif/srs_cpu_model.sv
// cpu and break module stand-in driving the sequencer's control inputs
`timescale 1ns/1ps
module srs_cpu_model (
  // clock
  input wire logic pclk,
  // to the sequencer
  output logic wait_exec,
  output logic stop_exec,
  output logic module_irq,
  output logic break_irq,
  output logic break_active
);
  initial begin
    wait_exec = 1'b0;
    stop_exec = 1'b0;
    module_irq = 1'b0;
    break_irq = 1'b0;
    break_active = 1'b0;
  end
  // one-cycle instruction pulse; returns at the edge that samples it
  task automatic exec(input bit stop);
    @(posedge pclk);
    if (stop) begin
      stop_exec <= 1'b1;
    end else begin
      wait_exec <= 1'b1;
    end
    @(posedge pclk);
    stop_exec <= 1'b0;
    wait_exec <= 1'b0;
  endtask
  // wake request after dly cycles, so the far side can be slow or prompt
  task automatic wake(input int dly, input bit brk);
    repeat (dly) @(posedge pclk);
    if (brk) begin
      break_irq <= 1'b1;
    end else begin
      module_irq <= 1'b1;
    end
  endtask
  task automatic drop();
    @(posedge pclk);
    module_irq <= 1'b0;
    break_irq <= 1'b0;
  endtask
  task automatic brk(input bit on);
    @(posedge pclk);
    break_active <= on;
  endtask
endmodule

// ===== verif/srs_core_tb_top.sv
// self-checking bench for the sequencer and reset cause block
`timescale 1ns/1ps
module srs_core_tb_top;
  import srs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [SRS_AW-1:0] paddr;
  logic [SRS_DW-1:0] pwdata, prdata, rd, m_rsr, seed;
  logic wait_exec, stop_exec, module_irq, break_irq, break_active, imask_clear, irq_stack_start;
  logic [5:0] ev;
  logic ev_pin, ev_wdog, ev_illegal_opcode_flag, ev_illegal_address_flag, ev_mon, ev_lv;
  assign {ev_pin, ev_wdog, ev_illegal_opcode_flag, ev_illegal_address_flag, ev_mon, ev_lv} = ev;
  logic vec_erased, irq_tst, cpu_en, x2_en, x4_en, wdog_en, fca;
  int err_count, n_checks, n;
  srs_cpu_model cpu_u (.pclk, .wait_exec, .stop_exec, .module_irq, .break_irq, .break_active);
  srs_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .wait_exec, .stop_exec, .module_irq, .imask_clear, .irq_stack_start, .break_active, .break_irq,
    .pin_reset_event(ev_pin), .watchdog_reset_event(ev_wdog), .illegal_opcode_event(ev_illegal_opcode_flag),
    .illegal_address_event(ev_illegal_address_flag), .monitor_entry_event(ev_mon), .low_voltage_event(ev_lv),
    .reset_vector_erased(vec_erased), .irq_at_test_voltage(irq_tst), .cpu_clock_en(cpu_en),
    .bus_clock_x2_en(x2_en), .bus_clock_x4_en(x4_en), .watchdog_enable(wdog_en), .flag_clear_allowed(fca));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_b(input logic got, input logic exp);
    chk_w({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k == 50) err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_rsr(input bit clr);
    apb(1'b0, SRS_RSR_OFF, 32'h0);
    chk_w(rd, m_rsr);
    if (clr) m_rsr = 32'h0;
  endtask
  // one-cycle reset source pulses; monitor entry counts only with erased vector and no test voltage
  task automatic fire(input logic [5:0] e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= 6'h00;
    if (!(vec_erased && !irq_tst)) e[1] = 1'b0;
    m_rsr = m_rsr | {25'h0, e, 1'b0};
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, vec_erased, irq_tst} = '0;
    err_count = 0;
    n_checks = 0;
    seed = 32'h0000a4ee;
    m_rsr = 32'h80;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk_b(cpu_en & x2_en & x4_en & wdog_en & fca, 1'b1);
    rd_rsr(1);
    rd_rsr(1);
    apb(1'b0, 12'h014, 32'h0);
    chk_b(err, 1'b1);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      vec_erased <= seed[8];
      irq_tst <= seed[9];
      fire(seed[5:0]);
      rd_rsr(1);
    end
    // a second power-on reset must drop every flag but the power-on one
    fire(6'h3f);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    m_rsr = 32'h80;
    rd_rsr(1);
    $display("reset cause test done");
    cpu_u.brk(1);
    fire(6'h20);
    chk_b(fca, 1'b0);
    rd_rsr(0);
    rd_rsr(0);
    cpu_u.brk(0);
    rd_rsr(1);
    apb(1'b1, SRS_BFC_OFF, 32'h80);
    apb(1'b0, SRS_BFC_OFF, 32'h0);
    chk_w(rd, 32'h80);
    cpu_u.brk(1);
    fire(6'h01);
    chk_b(fca, 1'b1);
    rd_rsr(1);
    cpu_u.brk(0);
    rd_rsr(1);
    $display("break test done");
    // interrupt, break, then a reset source: only the reset wake skips stacking
    for (int j = 0; j < 3; j++) begin
      cpu_u.exec(0);
      #1;
      chk_w({imask_clear, cpu_en, x2_en, x4_en, wdog_en}, 32'h17);
      if (j < 2) begin
        cpu_u.wake(j + 2, j);
        @(posedge pclk);
      end else begin
        fire(6'h01);
      end
      #1;
      chk_w({cpu_en, irq_stack_start}, j < 2 ? 32'h3 : 32'h2);
      cpu_u.drop();
    end
    rd_rsr(1);
    apb(1'b0, SRS_BSR_OFF, 32'h0);
    chk_w(rd, 32'h2);
    apb(1'b1, SRS_BSR_OFF, 32'h2);
    apb(1'b0, SRS_BSR_OFF, 32'h0);
    chk_w(rd, 32'h0);
    $display("wait test done");
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, SRS_CFG_OFF, j ? 32'h0 : 32'h6);
      cpu_u.exec(1);
      #1;
      chk_w({imask_clear, cpu_en, x2_en, x4_en, wdog_en}, j ? 32'h10 : 32'h14);
      cpu_u.wake(5, j);
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
      end while (cpu_en !== 1'b1 && n < 5000);
      chk_b(n >= (j ? 4096 : 32) && n <= (j ? 4098 : 34), 1'b1);
      chk_b(irq_stack_start, 1'b1);
      cpu_u.drop();
    end
    apb(1'b1, SRS_CFG_OFF, 32'h1);
    apb(1'b0, SRS_CFG_OFF, 32'h0);
    chk_w(rd, 32'h1);
    chk_b(wdog_en, 1'b0);
    apb(1'b0, SRS_MODE_OFF, 32'h0);
    chk_w(rd, 32'h0);
    $display("stop test done");
    finish_test();
  end
endmodule
